// ==== core/nvsr_regs.svh ====
// constants for the nonvolatile store/recall controller
// assumes a 40 MHz system clock; all times are in nanoseconds
`ifndef NVSR_REGS_SVH
`define NVSR_REGS_SVH

`define NVSR_CLK_PERIOD_NS 25

// operation times; plain defaults, override per part
`define NVSR_STORE_TIME_NS 1000000
`define NVSR_DELAY_TIME_NS 1000
`define NVSR_DRIVE_HIGH_NS 100
`define NVSR_POST_RELEASE_NS 100
`define NVSR_PWRUP_RECALL_NS 2000000
`define NVSR_RECALL_TIME_NS 100000

// nv opcodes
`define NVSR_OP_STORE 8'hA1
`define NVSR_OP_RECALL 8'hA2
`define NVSR_OP_AUTOSAVE_ON 8'hA3
`define NVSR_OP_AUTOSAVE_OFF 8'hA4

// reset values
`define NVSR_AUTOSAVE_RST 1'b1
`define NVSR_SYNC_RST 5'h11

`endif

// ==== core/nvsr_pkg.sv ====
// types for the nonvolatile store/recall controller
// used by nvsr_ctrl and by the test host, checker and bench
package nvsr_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_HW_WAIT,
    ST_HW_SKIP,
    ST_PF_WAIT,
    ST_ERASE,
    ST_PROG,
    ST_DRV_HI,
    ST_POST,
    ST_RCL_CLR,
    ST_RCL_COPY,
    ST_HALT
  } nvsr_state_e;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } nvsr_spi_s;

  typedef struct packed {
    logic nv_erase;
    logic nv_program;
    logic sram_clear;
    logic nv_copy;
  } nvsr_ops_s;

endpackage : nvsr_pkg

// ==== core/nvsr_ctrl.sv ====
// store/recall sequencer between sram array and nv shadow cells
// assumes spi pins, power-fail and busy/store pin are asynchronous
// and that the memory datapath honours access_block_o
//
// Behaviour
// - store from power-fail, instruction or pin
// - store erases first, then programs
// - block memory until store finishes
// - busy shown on pin and ready bit
// - auto and pin stores need a write
// - store instruction stores when idle, written or not
// - power-fail waits delay unblocked, then conditionally stores
// - instruction store blocks for store time
// - pin low, wait delay, conditional store
// - pin store blocks while pin low
// - pin pulled low during any store
// - pin driven high briefly after pin or instruction store
// - block post-release time after pin high
// - recall clears sram then copies nv
// - power-up recall always runs
// - autosave on/off commands, volatile setting
// - sample si on rising sck edges
// - first byte of frame is opcode
// - power-fail ignores commands, lets write finish
`include "nvsr_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module nvsr_ctrl #(
  parameter int STORE_NS = `NVSR_STORE_TIME_NS,
  parameter int DELAY_NS = `NVSR_DELAY_TIME_NS,
  parameter int DRVHI_NS = `NVSR_DRIVE_HIGH_NS,
  parameter int POST_NS = `NVSR_POST_RELEASE_NS,
  parameter int PWRUP_NS = `NVSR_PWRUP_RECALL_NS,
  parameter int RECALL_NS = `NVSR_RECALL_TIME_NS
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire nvsr_pkg::nvsr_spi_s spi_i,
  input wire logic power_fail_i,
  input wire logic sram_write_i,
  input wire logic busy_store_pin_i,
  output logic busy_store_pin_o,
  output logic busy_store_pin_oe_o,
  output logic access_block_o,
  output logic ready_busy_o,
  output nvsr_pkg::nvsr_ops_s nv_op_o,
  output logic autosave_en_o,
  output logic dirty_o,
  output logic [7:0] opcode_o,
  output logic opcode_stb_o
);

  localparam int CW = 24;
  localparam int PER = `NVSR_CLK_PERIOD_NS;
  localparam logic [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};

  // least times: round up, never below one cycle
  function automatic logic [CW-1:0] cyc_up(input int ns);
    int c;
    c = (ns + PER - 1) / PER;
    if (c < 1) begin
      c = 1;
    end
    return c[CW-1:0];
  endfunction : cyc_up

  localparam logic [CW-1:0] C_ERASE = cyc_up(STORE_NS / 2);
  localparam logic [CW-1:0] C_PROG = cyc_up(STORE_NS - STORE_NS / 2);
  localparam logic [CW-1:0] C_DELAY = cyc_up(DELAY_NS);
  localparam logic [CW-1:0] C_DRVHI = cyc_up(DRVHI_NS);
  localparam logic [CW-1:0] C_POST = cyc_up(POST_NS);
  localparam logic [CW-1:0] C_PU_H = cyc_up(PWRUP_NS / 2);
  localparam logic [CW-1:0] C_RCL_H = cyc_up(RECALL_NS / 2);

  // input synchronisers
  logic [4:0] raw;
  logic [4:0] s1_ff;
  logic [4:0] s2_ff;
  logic sck_d_ff;
  logic cs_n;
  logic sck;
  logic si;
  logic pf;
  logic pin_hi;

  assign raw = {spi_i.cs_n, spi_i.sck, spi_i.si, power_fail_i, busy_store_pin_i};
  assign cs_n = s2_ff[4];
  assign sck = s2_ff[3];
  assign si = s2_ff[2];
  assign pf = s2_ff[1];
  assign pin_hi = s2_ff[0];

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_ff <= `NVSR_SYNC_RST;
      s2_ff <= `NVSR_SYNC_RST;
      sck_d_ff <= 1'b0;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      sck_d_ff <= sck;
    end
  end

  // opcode capture
  logic [3:0] bit_cnt_ff;
  logic [7:0] sh_ff;
  logic got_ff;
  logic sck_rise;
  logic byte_end;
  logic [7:0] op_word;

  // rising sck only
  // a mode 3 idle-high clock gives no rise until it toggles
  assign sck_rise = ~cs_n & sck & ~sck_d_ff;
  assign byte_end = sck_rise & ~got_ff & (bit_cnt_ff == 4'h7);
  assign op_word = {sh_ff[6:0], si};

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      got_ff <= 1'b0;
    end else if (cs_n) begin
      bit_cnt_ff <= 4'h0;
      got_ff <= 1'b0;
    end else if (sck_rise && !got_ff) begin
      sh_ff <= op_word;
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
      got_ff <= byte_end;
    end
  end

  // sequencer
  nvsr_pkg::nvsr_state_e state_ff;
  nvsr_pkg::nvsr_state_e nxt_state;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic [CW-1:0] lim;
  logic tdone;
  logic cnt_clr;
  logic pu_ff;
  logic src_auto_ff;
  logic dirty_ff;
  logic nxt_dirty;
  logic as_en_ff;
  logic cmd_ok;
  logic is_store;
  logic is_recall;
  logic is_on;
  logic is_off;
  logic nv_done;

  assign cmd_ok = byte_end & (state_ff == nvsr_pkg::ST_IDLE) & ~pf;
  assign is_store = cmd_ok & (op_word == `NVSR_OP_STORE);
  assign is_recall = cmd_ok & (op_word == `NVSR_OP_RECALL);
  assign is_on = cmd_ok & (op_word == `NVSR_OP_AUTOSAVE_ON);
  assign is_off = cmd_ok & (op_word == `NVSR_OP_AUTOSAVE_OFF);

  // power-up recall uses its own longer time
  assign lim =
    (state_ff == nvsr_pkg::ST_ERASE) ? C_ERASE :
    (state_ff == nvsr_pkg::ST_PROG) ? C_PROG :
    (state_ff == nvsr_pkg::ST_HW_WAIT) ? C_DELAY :
    (state_ff == nvsr_pkg::ST_PF_WAIT) ? C_DELAY :
    (state_ff == nvsr_pkg::ST_DRV_HI) ? C_DRVHI :
    (state_ff == nvsr_pkg::ST_POST) ? C_POST :
    pu_ff ? C_PU_H : C_RCL_H;
  assign tdone = (cnt_ff + ONE == lim);

  // post time counts only once the pin reads high
  assign cnt_clr = (nxt_state != state_ff) |
    ((state_ff == nvsr_pkg::ST_POST) & ~pin_hi);
  assign nxt_cnt = cnt_clr ? {CW{1'b0}} : cnt_ff + ONE;

  // completion of a store or recall
  assign nv_done = tdone & ((state_ff == nvsr_pkg::ST_PROG) |
    (state_ff == nvsr_pkg::ST_RCL_COPY));
  // write wins over a same-cycle clear
  assign nxt_dirty = sram_write_i | (dirty_ff & ~nv_done);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      nvsr_pkg::ST_IDLE: begin
        if (pf) begin
          nxt_state = nvsr_pkg::ST_PF_WAIT;
        end else if (is_store) begin
          nxt_state = nvsr_pkg::ST_ERASE;
        end else if (is_recall) begin
          nxt_state = nvsr_pkg::ST_RCL_CLR;
        end else if (!pin_hi) begin
          nxt_state = nvsr_pkg::ST_HW_WAIT;
        end
      end
      nvsr_pkg::ST_HW_WAIT: begin
        if (pf) begin
          nxt_state = nvsr_pkg::ST_PF_WAIT;
        end else if (tdone) begin
          nxt_state = dirty_ff ? nvsr_pkg::ST_ERASE : nvsr_pkg::ST_HW_SKIP;
        end
      end
      nvsr_pkg::ST_HW_SKIP: begin
        // held low with nothing to save: wait so it does not retrigger
        if (pf) begin
          nxt_state = nvsr_pkg::ST_PF_WAIT;
        end else if (pin_hi) begin
          nxt_state = nvsr_pkg::ST_IDLE;
        end
      end
      nvsr_pkg::ST_PF_WAIT: begin
        if (tdone) begin
          nxt_state = (as_en_ff && dirty_ff) ? nvsr_pkg::ST_ERASE
                                             : nvsr_pkg::ST_HALT;
        end
      end
      nvsr_pkg::ST_ERASE: begin
        if (tdone) begin
          nxt_state = nvsr_pkg::ST_PROG;
        end
      end
      nvsr_pkg::ST_PROG: begin
        if (tdone) begin
          nxt_state = src_auto_ff ? nvsr_pkg::ST_HALT : nvsr_pkg::ST_DRV_HI;
        end
      end
      nvsr_pkg::ST_DRV_HI: begin
        if (tdone) begin
          nxt_state = nvsr_pkg::ST_POST;
        end
      end
      nvsr_pkg::ST_POST: begin
        // held while the pin stays low
        if (pf) begin
          nxt_state = nvsr_pkg::ST_PF_WAIT;
        end else if (pin_hi && tdone) begin
          nxt_state = nvsr_pkg::ST_IDLE;
        end
      end
      nvsr_pkg::ST_RCL_CLR: begin
        if (tdone) begin
          nxt_state = nvsr_pkg::ST_RCL_COPY;
        end
      end
      nvsr_pkg::ST_RCL_COPY: begin
        // recall held the pin low; let it read high first,
        // else the released pin looks like a pin store request
        if (tdone) begin
          nxt_state = nvsr_pkg::ST_HW_SKIP;
        end
      end
      nvsr_pkg::ST_HALT: begin
        // power is going away; only reset leaves here
        nxt_state = nvsr_pkg::ST_HALT;
      end
    endcase
  end

  // registered outputs, decoded from the next state
  logic n_store;
  logic n_rcl;
  logic n_drvhi;
  logic n_block;
  nvsr_pkg::nvsr_ops_s n_ops;

  assign n_store = (nxt_state == nvsr_pkg::ST_ERASE) |
    (nxt_state == nvsr_pkg::ST_PROG);
  assign n_rcl = (nxt_state == nvsr_pkg::ST_RCL_CLR) |
    (nxt_state == nvsr_pkg::ST_RCL_COPY);
  assign n_drvhi = (nxt_state == nvsr_pkg::ST_DRV_HI);
  // block through store, recall and release
  // wait states stay open so a finishing write can land
  assign n_block = n_store | n_rcl | n_drvhi |
    (nxt_state == nvsr_pkg::ST_POST) | (nxt_state == nvsr_pkg::ST_HALT);
  assign n_ops = '{nv_erase: nxt_state == nvsr_pkg::ST_ERASE,
                   nv_program: nxt_state == nvsr_pkg::ST_PROG,
                   sram_clear: nxt_state == nvsr_pkg::ST_RCL_CLR,
                   nv_copy: nxt_state == nvsr_pkg::ST_RCL_COPY};

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= nvsr_pkg::ST_RCL_CLR;
      cnt_ff <= {CW{1'b0}};
      pu_ff <= 1'b1;
      src_auto_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      if (nv_done) begin
        pu_ff <= 1'b0;
      end
      if (state_ff == nvsr_pkg::ST_PF_WAIT) begin
        src_auto_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dirty_ff <= 1'b0;
      as_en_ff <= `NVSR_AUTOSAVE_RST;
    end else begin
      dirty_ff <= nxt_dirty;
      if (is_on) begin
        as_en_ff <= 1'b1;
      end else if (is_off) begin
        as_en_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_store_pin_o <= 1'b0;
      busy_store_pin_oe_o <= 1'b1;
      access_block_o <= 1'b1;
      ready_busy_o <= 1'b1;
      nv_op_o <= '{nv_erase: 1'b0, nv_program: 1'b0,
                   sram_clear: 1'b1, nv_copy: 1'b0};
      autosave_en_o <= `NVSR_AUTOSAVE_RST;
      dirty_o <= 1'b0;
      opcode_o <= 8'h00;
      opcode_stb_o <= 1'b0;
    end else begin
      // brief active high, then weak pull-up
      busy_store_pin_o <= n_drvhi;
      busy_store_pin_oe_o <= n_store | n_rcl | n_drvhi;
      access_block_o <= n_block;
      ready_busy_o <= n_store | n_rcl;
      nv_op_o <= n_ops;
      autosave_en_o <= is_on | (as_en_ff & ~is_off);
      dirty_o <= nxt_dirty;
      if (byte_end) begin
        opcode_o <= op_word;
      end
      opcode_stb_o <= cmd_ok;
    end
  end

endmodule : nvsr_ctrl

`default_nettype wire

// ==== test/nvsr_spi_host.sv ====
// spi host model driving the controller's serial pins
// assumes send is entered just after a rising sys_clk edge
`timescale 1ns/1ps
`default_nettype none
module nvsr_spi_host (
  input wire logic sys_clk_i,
  output var nvsr_pkg::nvsr_spi_s spi_o
);
  initial spi_o = 3'b100;
  task automatic send(input logic [7:0] op, input logic mode3);
    spi_o.sck <= mode3;
    repeat (4) @(posedge sys_clk_i);
    spi_o.cs_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      spi_o.sck <= 1'b0;
      spi_o.si <= op[i];
      repeat (4) @(posedge sys_clk_i);
      spi_o.sck <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
    end
    spi_o.cs_n <= 1'b1;
    spi_o.sck <= mode3;
    // deselected data is junk, never the last bit
    spi_o.si <= ~op[0];
    repeat (4) @(posedge sys_clk_i);
  endtask : send
endmodule : nvsr_spi_host
`default_nettype wire

// ==== test/nvsr_ctrl_chk.sv ====
// assertion checker bound to nvsr_ctrl
// assumes the busy/store wire is resolved with a pull-up
`include "nvsr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module nvsr_ctrl_chk #(
  parameter int DRVHI_NS = `NVSR_DRIVE_HIGH_NS
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic sram_write_i,
  input wire logic power_fail_i,
  input wire logic busy_store_pin_i,
  input wire logic busy_store_pin_o,
  input wire logic busy_store_pin_oe_o,
  input wire logic access_block_o,
  input wire logic ready_busy_o,
  input wire nvsr_pkg::nvsr_ops_s nv_op_o,
  input wire logic autosave_en_o,
  input wire logic dirty_o,
  input wire logic [7:0] opcode_o,
  input wire logic opcode_stb_o
);
  localparam int C_DRVHI = (DRVHI_NS + `NVSR_CLK_PERIOD_NS - 1) / `NVSR_CLK_PERIOD_NS;
  logic storing;
  logic drv_hi;
  assign storing = nv_op_o.nv_erase || nv_op_o.nv_program;
  assign drv_hi = busy_store_pin_oe_o && busy_store_pin_o;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  erase_then_prog_a: assert property ($fell(nv_op_o.nv_erase) |-> nv_op_o.nv_program)
    else $error("erase not followed by program");
  store_busy_a: assert property (storing |-> access_block_o && drv_hi == 1'b0 && busy_store_pin_oe_o)
    else $error("store without block or low pin");
  cmd_store_a: assert property (opcode_stb_o && opcode_o == `NVSR_OP_STORE |-> ready_busy_o && nv_op_o.nv_erase)
    else $error("store opcode did not start store");
  clean_skip_a: assert property (!dirty_o |=> opcode_stb_o || !$rose(nv_op_o.nv_erase))
    else $error("store started on clean array");
  dirty_set_a: assert property (sram_write_i |=> dirty_o)
    else $error("write did not mark dirty");
  drive_high_a: assert property ($rose(drv_hi) |-> ##[C_DRVHI:C_DRVHI] !busy_store_pin_oe_o)
    else $error("drive-high length wrong");
  post_block_a: assert property ($fell(busy_store_pin_oe_o) && $past(busy_store_pin_o) |-> access_block_o[*2])
    else $error("block dropped before post time");
  pin_hold_a: assert property (access_block_o && !busy_store_pin_oe_o && !busy_store_pin_i |=> access_block_o)
    else $error("block dropped while pin low");
  recall_order_a: assert property ($fell(nv_op_o.sram_clear) |-> nv_op_o.nv_copy && access_block_o)
    else $error("clear not followed by copy");
  auto_off_a: assert property (opcode_stb_o && opcode_o == `NVSR_OP_AUTOSAVE_OFF |=> !autosave_en_o)
    else $error("autosave not disabled");
  auto_on_a: assert property (opcode_stb_o && opcode_o == `NVSR_OP_AUTOSAVE_ON |=> autosave_en_o)
    else $error("autosave not enabled");
  busy_mute_a: assert property (access_block_o && $past(access_block_o) |-> !opcode_stb_o)
    else $error("opcode taken while blocked");
  pf_mute_a: assert property ($past(power_fail_i, 2) |-> !opcode_stb_o)
    else $error("opcode taken during power fail");
  cover property (opcode_stb_o && opcode_o == `NVSR_OP_STORE);
  cover property ($fell(nv_op_o.nv_copy));
  cover property ($rose(drv_hi));
  cover property (access_block_o && !busy_store_pin_oe_o && !busy_store_pin_i);
endmodule : nvsr_ctrl_chk
bind nvsr_ctrl nvsr_ctrl_chk #(.DRVHI_NS(DRVHI_NS)) chk_u (.sys_clk_i, .resetn_i,
  .sram_write_i, .power_fail_i, .busy_store_pin_i, .busy_store_pin_o, .busy_store_pin_oe_o,
  .access_block_o, .ready_busy_o, .nv_op_o, .autosave_en_o, .dirty_o, .opcode_o,
  .opcode_stb_o);
`default_nettype wire

// ==== test/test_nvsr_ctrl.sv ====
// self-checking bench for nvsr_ctrl with an spi host model
// assumes shortened times: store 40, recall 20, power-up 40 cycles
`include "nvsr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_nvsr_ctrl;
  localparam int C_STORE = 40;
  localparam int C_RCL = 20;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic power_fail = 1'b0;
  logic sram_write = 1'b0;
  logic host_low = 1'b0;
  logic pin_o, pin_oe, block, busy, autosave, dirty, stb;
  logic [7:0] opcode;
  nvsr_pkg::nvsr_spi_s spi;
  nvsr_pkg::nvsr_ops_s nv_op;
  wire logic pin_w;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  // pull-up unless someone pulls; host only pulls while the pin idles
  assign pin_w = pin_oe ? pin_o : !host_low;
  nvsr_spi_host spi_u (.sys_clk_i, .spi_o(spi));
  nvsr_ctrl #(.STORE_NS(1000), .DELAY_NS(200), .DRVHI_NS(50),
    .PWRUP_NS(1000), .RECALL_NS(500)) dut_u (.sys_clk_i, .resetn_i, .spi_i(spi),
    .power_fail_i(power_fail), .sram_write_i(sram_write), .busy_store_pin_i(pin_w),
    .busy_store_pin_o(pin_o), .busy_store_pin_oe_o(pin_oe), .access_block_o(block),
    .ready_busy_o(busy), .nv_op_o(nv_op), .autosave_en_o(autosave), .dirty_o(dirty),
    .opcode_o(opcode), .opcode_stb_o(stb));
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_idle(output int len);
    len = 0;
    while (block !== 1'b0 && len < 2000) begin
      tick(1);
      len++;
    end
    chk(8'(len < 2000), 8'h01);
  endtask : wait_idle
  task automatic write(input int k);
    repeat (k) begin
      sram_write <= 1'b1;
      tick(1);
      sram_write <= 1'b0;
      tick(1);
    end
  endtask : write
  // pin store blocks for the store time or while the pin stays low
  function automatic int exp_block(input int hold);
    return (hold - 12 > C_STORE) ? hold - 12 : C_STORE;
  endfunction : exp_block
  task automatic pin_store(input int hold);
    int len;
    int n;
    host_low <= 1'b1;
    n = 0;
    repeat (hold) begin
      tick(1);
      n += int'(block === 1'b1);
    end
    host_low <= 1'b0;
    wait_idle(len);
    chk(8'(n + len >= exp_block(hold)), 8'h01);
  endtask : pin_store
  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    int len;
    int n;
    void'($urandom(36));
    tick(6);
    resetn_i <= 1'b1;
    wait_idle(len);
    chk(8'(len >= 40), 8'h01);
    chk(8'({dirty, autosave}), 8'h01);
    $display("power-up test done");
    spi_u.send(`NVSR_OP_STORE, 1'b0);
    chk(8'(busy), 8'h01);
    wait_idle(len);
    chk(8'(len >= C_STORE - 6), 8'h01);
    $display("store opcode test done");
    host_low <= 1'b1;
    n = 0;
    repeat (30) begin
      tick(1);
      n += int'(block !== 1'b0);
    end
    host_low <= 1'b0;
    chk(8'(n), 8'h00);
    tick(4);
    // corner: pin still held low after the store ends
    write(1);
    tick(1);
    pin_store(90);
    $display("pin hold test done");
    for (int t = 0; t < 8; t++) begin
      write($urandom_range(4, 1));
      tick(1);
      chk(8'(dirty), 8'h01);
      case ($urandom_range(2))
        0: begin
          pin_store($urandom_range(100, 20));
        end
        1: begin
          spi_u.send(`NVSR_OP_RECALL, 1'($urandom_range(1)));
          chk(8'(nv_op), 8'h02);
          wait_idle(len);
          chk(8'(len >= C_RCL - 6), 8'h01);
        end
        default: begin
          spi_u.send(8'($urandom_range(8'hA0)), 1'b0);
          chk(8'(block), 8'h00);
          spi_u.send(`NVSR_OP_STORE, 1'b1);
          wait_idle(len);
        end
      endcase
      chk(8'(dirty), 8'h00);
      $display("random test %0d done", t);
    end
    for (int m = 0; m < 2; m++) begin
      spi_u.send(m ? `NVSR_OP_AUTOSAVE_ON : `NVSR_OP_AUTOSAVE_OFF, 1'b1);
      chk(8'(autosave), 8'(m));
      write(1);
      power_fail <= 1'b1;
      n = 0;
      repeat (100) begin
        tick(1);
        n += int'(nv_op.nv_program === 1'b1);
      end
      chk(8'(n > 0), 8'(m));
      spi_u.send(`NVSR_OP_STORE, 1'b0);
      chk(8'({block, nv_op}), 8'h10);
      resetn_i <= 1'b0;
      tick(6);
      power_fail <= 1'b0;
      resetn_i <= 1'b1;
      wait_idle(len);
      $display("power-fail test %0d done", m);
    end
    report_and_stop();
  end
endmodule : test_nvsr_ctrl
`default_nettype wire
